// >>> common/qpsc_pkg.sv
/*
  Constants, opcodes, state encoding and timing figures of the quad
  potentiometer serial command unit.
  Assumes a 50 MHz system clock; all cycle counts derive from it.
*/
package qpsc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int POT_COUNT = 4;
  localparam int REG_COUNT = 4;
  localparam int STORE_COUNT = 16;
  localparam int POS_W = 6;
  localparam int TAP_COUNT = 64;
  localparam int BYTE_W = 8;
  localparam int PIN_COUNT = 5;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [5:0] POS_MAX = 6'h3F;
  localparam logic [5:0] POS_MIN = 6'h00;
  localparam logic [5:0] POS_STEP = 6'h01;
  localparam logic [5:0] WIPER_RESET = 6'h00;
  localparam logic [5:0] PRESET_RESET = 6'h00;
  localparam logic [63:0] TAP_RESET = 64'h0000000000000001;
  localparam logic [3:0] DEV_TYPE_ID = 4'hA; // Arbitrary value
  localparam logic [1:0] SEL_ZERO = 2'h0;
  localparam logic [1:0] POT_LAST = 2'h3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] STATUS_LOW = 4'h1;
  // Pin order: strap1, strap0, serial in, select (idles high), clock
  localparam logic [4:0] PIN_RESET = 5'h02;

  // ----------------------------------------------------------------
  // Byte fields
  // ----------------------------------------------------------------
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int REGSEL_MSB = 3;
  localparam int REGSEL_LSB = 2;
  localparam int POTSEL_MSB = 1;
  localparam int POTSEL_LSB = 0;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_COPY = 4'hD;
  localparam logic [3:0] OP_STORE = 4'hE;
  localparam logic [3:0] OP_GCOPY = 4'h1;
  localparam logic [3:0] OP_GSTORE = 4'h8;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_PRESET = 4'hB;
  localparam logic [3:0] OP_WR_PRESET = 4'hC;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_STATUS = 4'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int NV_STORE_TIME_MS = 10;
  localparam int WIPER_SETTLE_TIME_NS = 2000;
  localparam int NV_STORE_CYCLES =
    (NV_STORE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIPER_SETTLE_CYCLES =
    (WIPER_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NV_CNT_W = 20;
  localparam int SETTLE_CNT_W = 8;

  // ----------------------------------------------------------------
  // Frame states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ID = 8'h02,
    S_INSTR = 8'h04,
    S_DIN = 8'h08,
    S_DOUT = 8'h10,
    S_STEP = 8'h20,
    S_IGNORE = 8'h40,
    S_DONE = 8'h80
  } qpsc_state_t;

endpackage

// >>> core/qpsc_countdown.sv
/*
  One-shot countdown: busy for exactly CYCLES clocks after start.
  Assumes CYCLES is at least one and fits CNT_W bits.
*/
`timescale 1ns/10ps
module qpsc_countdown #(
  parameter int CNT_W = 8,
  parameter int CYCLES = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  logic [CNT_W-1:0] cnt;
  wire last = (cnt == CNT_W'(1));

  // Restart on start, count down while busy
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && last && !start_i;
      if (start_i) begin
        cnt <= CNT_W'(CYCLES);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        cnt <= cnt - CNT_W'(1);
        busy_o <= !last;
      end
    end
  end

endmodule

// >>> core/qpsc_pin_filter.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/10ps
module qpsc_pin_filter #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic pin_i,
  output logic level_o
);

  logic s1;
  logic s2;
  logic s3;

  // Level changes only once the last two stages agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      level_o <= RESET_LEVEL;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end

endmodule

// >>> core/qpsc_serial_unit.sv
/*
  Serial command unit of a quad digital potentiometer: frame decoder,
  wiper position counters, preset stores and wiper tap outputs.
  Assumes the host drives the serial clock idle low, samples on rising
  edges, and the serial clock is far slower than clk_i.
*/
// Operation
// R01: Preset writes commit on select rising
// R02: Busy flag while store runs, readable
// R03: First byte upper nibble is device type
// R04: Low identification bits must match strap pins
// R05: Host sends zeros in middle identification bits
// R06: Second byte: opcode, register, potentiometer
// R07: 1101 copies preset into chosen wiper
// R08: Wiper output follows copy after settle delay
// R09: 1110 stores wiper into preset, nonvolatile
// R10: 0001 global copies presets into wipers
// R11: 1000 global stores wipers into presets
// R12: 1001 shifts wiper counter out
// R13: 1010 loads wiper counter from third byte
// R14: 1011 shifts addressed preset out
// R15: 1100 writes third byte into preset
// R16: 0101 0001 returns busy flag bit
// R17: 0010 enters step mode until deselect
// R18: Step moves wiper up or down
// R19: Host holds direction through clock high
// R20: Six bits decode to one-hot tap
// R21: Sample on rising, change output on falling
// R22: Deselected means output not driven
// R23: Step saturates at both ends
// R24: Mismatched identification ignores rest of frame
`timescale 1ns/10ps
module qpsc_serial_unit
  import qpsc_pkg::*;
#(
  parameter int NV_STORE_CYC = NV_STORE_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic [1:0] chip_strap_pins_i,
  output logic so_o,
  output logic so_oe_o,
  output logic [POT_COUNT-1:0][TAP_COUNT-1:0] wiper_tap_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [TAP_COUNT-1:0] qpsc_tap_decode(input logic [POS_W-1:0] pos);
    qpsc_tap_decode = TAP_RESET << pos;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pins_f;
  wire [PIN_COUNT-1:0] pins_raw = {chip_strap_pins_i, si_i, cs_n_i, sck_i};

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      qpsc_pin_filter #(
        .RESET_LEVEL(PIN_RESET[g])
      ) u_filter (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(pins_raw[g]),
        .level_o(pins_f[g])
      );
    end
  endgenerate

  wire sck_f = pins_f[0];
  wire cs_n_f = pins_f[1];
  wire si_f = pins_f[2];
  wire [1:0] strap_f = pins_f[4:3];

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  qpsc_state_t st;
  qpsc_state_t next_st;
  logic sck_q;
  logic cs_q;
  logic [2:0] bit_cnt;
  logic [BYTE_W-1:0] shin;
  logic [BYTE_W-1:0] instr;
  logic [BYTE_W-1:0] out_sh;
  logic [POS_W-1:0] staged;
  logic commit_armed;
  logic [POT_COUNT-1:0][POS_W-1:0] wiper;
  logic [POT_COUNT-1:0][POS_W-1:0] next_wiper;
  logic [STORE_COUNT-1:0][POS_W-1:0] preset;
  logic [POT_COUNT-1:0] pending;
  logic nv_busy;
  logic settle_done;

  // ----------------------------------------------------------------
  // Edge detection on filtered pins
  // ----------------------------------------------------------------
  wire sck_rise = sck_f && !sck_q; // see R21
  wire sck_fall = !sck_f && sck_q; // see R21
  wire cs_fall = !cs_n_f && cs_q;
  wire cs_rise = cs_n_f && !cs_q;

  // Incoming byte and its fields
  wire [BYTE_W-1:0] next_shin = {shin[BYTE_W-2:0], si_f};
  wire byte_done = sck_rise && (bit_cnt == LAST_BIT);
  wire [3:0] opc = next_shin[OPC_MSB:OPC_LSB];
  wire [1:0] rsel = next_shin[REGSEL_MSB:REGSEL_LSB];
  wire [1:0] psel = next_shin[POTSEL_MSB:POTSEL_LSB];
  wire [3:0] idx = {rsel, psel};

  // Fields of the held instruction
  wire [3:0] h_opc = instr[OPC_MSB:OPC_LSB];
  wire [1:0] h_rsel = instr[REGSEL_MSB:REGSEL_LSB];
  wire [1:0] h_psel = instr[POTSEL_MSB:POTSEL_LSB];
  wire [3:0] h_idx = {h_rsel, h_psel};

  // Identification byte checks
  wire id_type_ok = (opc == DEV_TYPE_ID); // see R03
  wire strap_ok = (psel == strap_f); // see R04

  // Instruction decode
  wire instr_done = (st == S_INSTR) && byte_done; // see R06
  wire is_copy = (opc == OP_COPY); // see R07
  wire is_store = (opc == OP_STORE); // see R09
  wire is_gcopy = (opc == OP_GCOPY) && (psel == SEL_ZERO); // see R10
  wire is_gstore = (opc == OP_GSTORE) && (psel == SEL_ZERO); // see R11
  wire is_rd_wiper = (opc == OP_RD_WIPER) && (rsel == SEL_ZERO); // see R12
  wire is_wr_wiper = (opc == OP_WR_WIPER) && (rsel == SEL_ZERO); // see R13
  wire is_rd_preset = (opc == OP_RD_PRESET); // see R14
  wire is_wr_preset = (opc == OP_WR_PRESET); // see R15
  wire is_status = (next_shin == {OP_STATUS, STATUS_LOW}); // see R16
  wire is_step = (opc == OP_STEP) && (rsel == SEL_ZERO); // see R17
  wire is_xfer = is_copy || is_store || is_gcopy || is_gstore;
  wire is_read = is_rd_wiper || is_rd_preset || is_status;
  wire is_write = is_wr_wiper || is_wr_preset;

  // State after the instruction byte; unknown codes drop the frame
  wire qpsc_state_t instr_next_st = is_read ? S_DOUT :
                                    is_write ? S_DIN :
                                    is_step ? S_STEP :
                                    is_xfer ? S_DONE : S_IGNORE;

  // Transfers and commits
  wire copy_start = instr_done && (is_copy || is_gcopy);
  wire din_done = (st == S_DIN) && byte_done;
  wire arm_commit = (instr_done && (is_store || is_gstore)) ||
                    (din_done && (h_opc == OP_WR_PRESET));
  wire commit_fire = cs_rise && commit_armed && !nv_busy; // see R01
  wire step_edge = (st == S_STEP) && sck_rise; // see R18

  // Read data selection
  wire [BYTE_W-1:0] rd_data = is_rd_wiper ? BYTE_W'(wiper[psel]) :
                              is_rd_preset ? BYTE_W'(preset[idx]) :
                              BYTE_W'(nv_busy); // see R02

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (cs_rise) begin
      next_st = S_IDLE; // see R22
    end else if (cs_fall) begin
      next_st = S_ID;
    end else if (byte_done) begin
      unique case (st)
        S_ID: next_st = (id_type_ok && strap_ok) ? S_INSTR : S_IGNORE; // see R24
        S_INSTR: next_st = instr_next_st;
        S_DIN, S_DOUT: next_st = S_DONE;
        S_IDLE, S_STEP, S_IGNORE, S_DONE: next_st = st; // see R17
      endcase
    end
  end

  // State, edges and bit counting
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= S_IDLE;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      bit_cnt <= '0;
      shin <= '0;
    end else begin
      st <= next_st;
      sck_q <= sck_f;
      cs_q <= cs_n_f;
      bit_cnt <= cs_fall ? '0 : (sck_rise ? bit_cnt + 3'h1 : bit_cnt);
      shin <= sck_rise ? next_shin : shin;
    end
  end

  // Held instruction, write data and commit arming
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      instr <= '0;
      staged <= PRESET_RESET;
      commit_armed <= 1'b0;
    end else begin
      if (instr_done) begin
        instr <= next_shin;
      end
      if (din_done) begin
        staged <= next_shin[POS_W-1:0]; // see R15
      end
      if (arm_commit) begin
        commit_armed <= 1'b1;
      end else if (cs_fall || cs_rise) begin
        commit_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Load on instruction, shift on falling clock, drive only in reads
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_sh <= '0;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      if (instr_done) begin
        out_sh <= rd_data; // see R12
      end else if ((st == S_DOUT) && sck_fall) begin
        out_sh <= out_sh << 1; // see R21
      end
      if ((st == S_DOUT) && sck_fall) begin
        so_o <= out_sh[BYTE_W-1]; // see R14
      end
      so_oe_o <= (st == S_DOUT); // see R22
    end
  end

  // ----------------------------------------------------------------
  // Wiper position counters and tap outputs
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < POT_COUNT; g++) begin : g_pot
      localparam logic [1:0] PIDX = 2'(g);
      wire copy_p = instr_done && ((is_copy && (psel == PIDX)) || is_gcopy); // see R10
      wire din_p = din_done && (h_opc == OP_WR_WIPER) && (h_psel == PIDX); // see R13
      wire step_p = step_edge && (h_psel == PIDX);
      wire at_top = (wiper[g] == POS_MAX);
      wire at_bot = (wiper[g] == POS_MIN);
      // Saturating one-segment move
      wire [POS_W-1:0] step_val = si_f ? (at_top ? wiper[g] : wiper[g] + POS_STEP) :
                                         (at_bot ? wiper[g] : wiper[g] - POS_STEP); // see R23
      assign next_wiper[g] = copy_p ? preset[{rsel, PIDX}] : // see R07
                             din_p ? next_shin[POS_W-1:0] :
                             step_p ? step_val : wiper[g]; // see R18

      // Counter, settle hold and registered tap decode
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          wiper[g] <= WIPER_RESET;
          pending[g] <= 1'b0;
          wiper_tap_o[g] <= TAP_RESET;
        end else begin
          wiper[g] <= next_wiper[g];
          if (copy_p) begin
            pending[g] <= 1'b1; // see R08
          end else if (settle_done) begin
            pending[g] <= 1'b0;
          end
          if (!pending[g]) begin
            wiper_tap_o[g] <= qpsc_tap_decode(wiper[g]); // see R20
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Preset stores
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < STORE_COUNT; g++) begin : g_store
      localparam logic [3:0] SIDX = 4'(g);
      wire wr_data = (h_opc == OP_WR_PRESET) && (h_idx == SIDX);
      wire wr_one = (h_opc == OP_STORE) && (h_idx == SIDX); // see R09
      wire wr_all = (h_opc == OP_GSTORE) && (h_rsel == SIDX[REGSEL_MSB:REGSEL_LSB]); // see R11
      wire [POS_W-1:0] src = wr_data ? staged : wiper[SIDX[POTSEL_MSB:POTSEL_LSB]];

      // Commit only at the end of a complete frame
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          preset[g] <= PRESET_RESET;
        end else if (commit_fire && (wr_data || wr_one || wr_all)) begin
          preset[g] <= src; // see R01
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  qpsc_countdown #(
    .CNT_W(NV_CNT_W),
    .CYCLES(NV_STORE_CYC)
  ) u_nv_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(commit_fire),
    .busy_o(nv_busy),
    .done_o()
  );

  qpsc_countdown #(
    .CNT_W(SETTLE_CNT_W),
    .CYCLES(WIPER_SETTLE_CYCLES)
  ) u_settle_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(copy_start),
    .busy_o(),
    .done_o(settle_done)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_id_type: assert property ( // see R03
    @(posedge clk_i) disable iff (!resetn_i)
    (st == S_ID && byte_done && !id_type_ok) |=> (st == S_IGNORE))
    else $error("wrong device type not ignored");

  a_strap_match: assert property ( // see R04
    @(posedge clk_i) disable iff (!resetn_i)
    (st == S_ID && byte_done && !strap_ok) |=> (st == S_IGNORE))
    else $error("strap mismatch not ignored");

  a_commit_cs: assert property ( // see R01
    @(posedge clk_i) disable iff (!resetn_i)
    $changed(preset) |-> $past(cs_rise))
    else $error("preset changed outside select rising");

  a_busy_commit: assert property ( // see R02
    @(posedge clk_i) disable iff (!resetn_i)
    commit_fire |=> nv_busy)
    else $error("busy flag not raised by store");

  a_copy_wiper: assert property ( // see R07
    @(posedge clk_i) disable iff (!resetn_i)
    (instr_done && is_copy) |=> (wiper[$past(psel)] == $past(preset[idx])))
    else $error("copy did not load wiper");

  a_settle_hold: assert property ( // see R08
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(pending[0]) |-> ##1 $stable(wiper_tap_o[0]))
    else $error("tap moved before settle delay");

  a_global_copy: assert property ( // see R10
    @(posedge clk_i) disable iff (!resetn_i)
    (instr_done && is_gcopy) |=> (wiper[POT_LAST] == $past(preset[{rsel, POT_LAST}])))
    else $error("global copy missed last wiper");

  a_status_busy: assert property ( // see R16
    @(posedge clk_i) disable iff (!resetn_i)
    (instr_done && is_status) |=> (out_sh == BYTE_W'($past(nv_busy))))
    else $error("status byte does not hold busy flag");

  a_step_up: assert property ( // see R18
    @(posedge clk_i) disable iff (!resetn_i)
    (step_edge && si_f && wiper[h_psel] != POS_MAX)
      |=> (wiper[$past(h_psel)] == $past(wiper[h_psel]) + POS_STEP))
    else $error("step up did not advance wiper");

  a_step_sat: assert property ( // see R23
    @(posedge clk_i) disable iff (!resetn_i)
    (step_edge && si_f && wiper[h_psel] == POS_MAX) |=> (wiper[$past(h_psel)] == POS_MAX))
    else $error("step wrapped at top");

  a_so_hiz: assert property ( // see R22
    @(posedge clk_i) disable iff (!resetn_i)
    (cs_n_f && $past(cs_n_f, 3)) |-> !so_oe_o)
    else $error("output driven while deselected");

  a_tap_onehot: assert property ( // see R20
    @(posedge clk_i) disable iff (!resetn_i)
    $onehot(wiper_tap_o[0]))
    else $error("tap select not one-hot");

  a_ignore_quiet: assert property ( // see R24
    @(posedge clk_i) disable iff (!resetn_i)
    (st == S_IGNORE) |=> !so_oe_o)
    else $error("output driven in ignored frame");

endmodule

// >>> verification/qpsc_host_model.sv
/*
  Host serial controller model: mode 0, MSB first, select low per frame.
  Assumes clk_i is the bench clock; a link half period is four of its cycles.
*/
`timescale 1ns/10ps
module qpsc_host_model (
  input wire logic clk_i,
  input wire logic so_line_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  // Idle bus: clock low, deselected
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // One link half period
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  // Data set while clock low, held through high phase
  // Read line taken late in the high phase: filtered output lags the fall
  task automatic bit_x(input logic b, output logic r);
    si_o = b;
    half();
    sck_o = 1'b1;
    half();
    r = so_line_i;
    sck_o = 1'b0;
  endtask
  // Frame: id, instruction, then n bits cycling through d
  task automatic frame(input logic [7:0] id, input logic [7:0] ins, input logic [7:0] d,
    input int n, output logic [7:0] rd);
    logic r;
    rd = 8'h00;
    cs_n_o = 1'b0;
    half();
    for (int i = 7; i >= 0; i--) bit_x(id[i], r);
    for (int i = 7; i >= 0; i--) bit_x(ins[i], r);
    for (int i = 0; i < n; i++) begin
      bit_x(d[7 - i % 8], r);
      rd = {rd[6:0], r};
    end
    half();
    cs_n_o = 1'b1;
    si_o = ~si_o; // Released line shows no stale level
    repeat (3) half();
  endtask
endmodule

// >>> verification/quad_pot_serial_command_unit_bench.sv
/*
  Self-checking bench of the serial unit against a behavioural model.
  Assumes the host model drives the link; stores run 600 cycles here.
*/
`timescale 1ns/10ps
module quad_pot_serial_command_unit_bench;
  import qpsc_pkg::*;
  localparam int NV_CYC = 600;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sck_i, cs_n_i, si_i, so_o, so_oe_o;
  logic idle_pat = 1'b0;
  int n_oe = 0;
  logic [1:0] chip_strap_pins_i = 2'h0;
  logic [POT_COUNT-1:0][TAP_COUNT-1:0] wiper_tap_o;
  logic [7:0] id, rd, d;
  int n_fail = 0;
  int n_compared = 0;
  int wiper [4];
  int preset [16];
  int r;
  // Undriven output line toggles so no stale level passes
  wire so_line = so_oe_o ? so_o : idle_pat;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    idle_pat <= ~idle_pat;
    n_oe <= n_oe + int'(so_oe_o);
  end
  qpsc_serial_unit #(.NV_STORE_CYC(NV_CYC)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .chip_strap_pins_i(chip_strap_pins_i),
    .so_o(so_o), .so_oe_o(so_oe_o), .wiper_tap_o(wiper_tap_o));
  qpsc_host_model host_u (.clk_i(clk_i), .so_line_i(so_line), .sck_o(sck_i),
    .cs_n_o(cs_n_i), .si_o(si_i));
  // ----------------------------------------------------------------
  // Compare and command tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_tap(int p);
    logic [63:0] e;
    e = 64'h1 << wiper[p];
    n_compared++;
    if (wiper_tap_o[p] !== e) begin
      n_fail++;
      $display("CHECK FAILED tap%0d expected %h seen %h", p, e, wiper_tap_o[p]);
    end
  endtask
  task automatic op(logic [3:0] opc, logic [1:0] rs, logic [1:0] ps, logic [7:0] dd, int n);
    host_u.frame(id, {opc, rs, ps}, dd, n, rd);
  endtask
  task automatic step_chk(int p, int v, logic [7:0] dd);
    op(OP_WR_WIPER, 2'h0, 2'(p), 8'(v), 8);
    op(OP_STEP, 2'h0, 2'(p), dd, 8);
    for (int i = 7; i >= 0; i--) v = dd[i] ? (v < 63 ? v + 1 : 63) : (v > 0 ? v - 1 : 0);
    wiper[p] = v;
    op(OP_RD_WIPER, 2'h0, 2'(p), 8'h00, 8);
    chk_byte("step", 8'(v), rd);
    chk_tap(p);
  endtask
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog against a hung link
  initial begin
    #1200000;
    n_fail++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(64064));
    chip_strap_pins_i = 2'($urandom);
    id = {DEV_TYPE_ID, 2'h0, chip_strap_pins_i};
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    for (int p = 0; p < 4; p++) chk_tap(p);
    // Preset writes commit at select rise, busy while storing
    for (int k = 0; k < 16; k++) begin
      d = 8'($urandom);
      op(OP_WR_PRESET, 2'(k >> 2), 2'(k), d, 8);
      preset[k] = d[5:0];
      op(OP_STATUS, 2'h0, 2'h1, 8'h00, 8);
      chk_byte("busy", 8'h01, rd);
      repeat (NV_CYC) @(negedge clk_i);
      op(OP_RD_PRESET, 2'(k >> 2), 2'(k), 8'h00, 8);
      chk_byte("preset", 8'(preset[k]), rd);
    end
    op(OP_STATUS, 2'h0, 2'h1, 8'h00, 8);
    chk_byte("idle", 8'h00, rd);
    // Wiper write, read, copy with settle delay, store
    for (int p = 0; p < 4; p++) begin
      r = $urandom_range(3);
      op(OP_WR_WIPER, 2'h0, 2'(p), 8'(~preset[r * 4 + p]), 8);
      wiper[p] = 63 - preset[r * 4 + p];
      op(OP_RD_WIPER, 2'h0, 2'(p), 8'h00, 8);
      chk_byte("wiper", 8'(wiper[p]), rd);
      op(OP_COPY, 2'(r), 2'(p), 8'h00, 0);
      chk_tap(p);
      wiper[p] = preset[r * 4 + p];
      repeat (120) @(negedge clk_i);
      chk_tap(p);
      d = 8'($urandom);
      op(OP_WR_WIPER, 2'h0, 2'(p), d, 8);
      wiper[p] = d[5:0];
      op(OP_RD_WIPER, 2'h0, 2'(p), 8'h00, 8);
      chk_byte("wiper", 8'(wiper[p]), rd);
      chk_tap(p);
      r = $urandom_range(3);
      op(OP_STORE, 2'(r), 2'(p), 8'h00, 0);
      preset[r * 4 + p] = wiper[p];
      repeat (NV_CYC) @(negedge clk_i);
      op(OP_RD_PRESET, 2'(r), 2'(p), 8'h00, 8);
      chk_byte("store", 8'(wiper[p]), rd);
    end
    // Global copy then global store to another register
    r = $urandom_range(3);
    op(OP_GCOPY, 2'(r), 2'h0, 8'h00, 0);
    for (int q = 0; q < 4; q++) wiper[q] = preset[r * 4 + q];
    repeat (120) @(negedge clk_i);
    for (int q = 0; q < 4; q++) chk_tap(q);
    op(OP_WR_WIPER, 2'h0, 2'h1, 8'h2A, 8);
    wiper[1] = 8'h2A;
    op(OP_GSTORE, 2'(r ^ 1), 2'h0, 8'h00, 0);
    repeat (NV_CYC) @(negedge clk_i);
    for (int q = 0; q < 4; q++) begin
      op(OP_RD_PRESET, 2'(r ^ 1), 2'(q), 8'h00, 8);
      chk_byte("gstore", 8'(wiper[q]), rd);
    end
    // Step mode with saturation at both ends
    step_chk(0, 61, 8'hFF);
    step_chk(1, 3, 8'h00);
    step_chk(2, $urandom_range(63), 8'($urandom));
    // Wrong type or strap bits leave the frame ignored
    for (int j = 0; j < 3; j++) begin
      d = id ^ (j == 2 ? 8'h40 : 8'(j + 1));
      r = n_oe;
      host_u.frame(d, {OP_RD_WIPER, 4'h0}, 8'h00, 8, rd);
      chk_byte("oe", 8'h00, 8'(n_oe - r));
      host_u.frame(d, {OP_WR_WIPER, 4'h0}, 8'(~wiper[0]), 8, rd);
    end
    op(OP_RD_WIPER, 2'h0, 2'h0, 8'h00, 8);
    chk_byte("ignored", 8'(wiper[0]), rd);
    end_sim();
  end
endmodule
